// ==== pkg/ssc_regs.svh ====
// Register offsets, fields and reset values of the strobe channel block
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH
`define SSC_OFS_CTRL 8'h00
`define SSC_OFS_INIT 8'h04
`define SSC_OFS_HIGH 8'h08
`define SSC_OFS_LOW 8'h0c
`define SSC_OFS_MASK 8'h10
`define SSC_OFS_SMPCFG 8'h14
`define SSC_OFS_STAT 8'h18
`define SSC_OFS_TGT 8'h1c
`define SSC_OFS_CNT 8'h20
`define SSC_OFS_MUX 8'h24
`define SSC_CTRL_COUNTER_ENABLE 0
`define SSC_CTRL_CHEN 1
`define SSC_CTRL_MSKEN 2
`define SSC_CTRL_ARLEN 3
`define SSC_CTRL_IRQEN 4
`define SSC_CTRL_SMPIRQEN 5
`define SSC_CTRL_INV 6
`define SSC_CTRL_PSC_LSB 8
`define SSC_SMP_FE 0
`define SSC_SMP_RE 1
`define SSC_SMP_EN_LSB 4
`define SSC_SMP_PTRN_LSB 8
`define SSC_SMP_EXP_LSB 12
`define SSC_STAT_EVT 0
`define SSC_STAT_ACT 1
`define SSC_STAT_SMP_LSB 4
`define SSC_RST_INIT 16'h0000
`define SSC_RST_DUR 16'h0001
`define SSC_STRB_CYCLES 1
`endif

// ==== pkg/ssc_pkg.sv ====
// Types of the strobe channel block
package ssc_pkg;
  typedef enum logic [1:0] {
    SSC_PT_CHANGED,
    SSC_PT_SAME,
    SSC_PT_EQ_EXP,
    SSC_PT_NE_EXP
  } ssc_pattern_t;
  typedef enum logic {
    SSC_OUT_LOW,
    SSC_OUT_HIGH
  } ssc_level_t;
endpackage

// ==== hw/ssc_strobe_channel.sv ====
// Strobe compare channel with input sampling and Wishbone register slave
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_strobe_channel (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick_32k,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] sample_pins,
  output logic strobe_out,
  output logic strobe_out_n,
  output logic irq,
  output logic wakeup
);
  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] low_ones(input logic [3:0] w);
    low_ones = 16'hffff >> (5'd16 - {1'b0, w});
  endfunction

  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    integer i;
    wr_merge = old;
    for (i = 0; i < 4; i = i + 1)
      if (sel[i])
        wr_merge[i*8 +: 8] = nw[i*8 +: 8];
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] tick_sync_q;
  logic tick_prev_q;
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  logic tick;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tick_sync_q <= 2'h0;
      tick_prev_q <= 1'b0;
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end
    else
    begin
      tick_sync_q <= {tick_sync_q[0], tick_32k};
      tick_prev_q <= tick_sync_q[1];
      pin_s1_q <= sample_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  // One step per counter clock; the 32 kHz clock is a slow sampled input
  assign tick = tick_sync_q[1] & ~tick_prev_q;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [15:0] init_q;
  logic [15:0] high_q;
  logic [15:0] low_q;
  logic [31:0] mask_q;
  logic [31:0] smpcfg_q;
  logic [11:0] mux_q;
  logic [31:0] cnt_q;
  logic [15:0] tgt_q;
  logic evt_q;
  logic act_q;
  logic [2:0] smp_q;
  logic wb_req;
  logic wr;
  logic cnt_wr;
  logic stat_clr;
  logic [31:0] rd_d;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_req & wb_we_i;
  assign cnt_wr = wr && (wb_adr_i == `SSC_OFS_CNT);
  assign stat_clr = wr && (wb_adr_i == `SSC_OFS_STAT);

  wire logic counter_enable = ctrl_q[`SSC_CTRL_COUNTER_ENABLE];
  wire logic chen = ctrl_q[`SSC_CTRL_CHEN];
  wire logic msken = ctrl_q[`SSC_CTRL_MSKEN];
  wire logic arlen = ctrl_q[`SSC_CTRL_ARLEN];
  wire logic [3:0] per_w = mask_q[3:0];
  wire logic [3:0] ot_w = mask_q[11:8];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_q <= 32'h0;
      init_q <= `SSC_RST_INIT;
      high_q <= `SSC_RST_DUR;
      low_q <= `SSC_RST_DUR;
      mask_q <= 32'h0;
      smpcfg_q <= 32'h0;
      mux_q <= 12'h000;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `SSC_OFS_CTRL: ctrl_q <= wr_merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0f7f;
        `SSC_OFS_INIT: init_q <= 16'(wr_merge({16'h0, init_q}, wb_dat_i, wb_sel_i));
        `SSC_OFS_HIGH: high_q <= 16'(wr_merge({16'h0, high_q}, wb_dat_i, wb_sel_i));
        `SSC_OFS_LOW: low_q <= 16'(wr_merge({16'h0, low_q}, wb_dat_i, wb_sel_i));
        `SSC_OFS_MASK: mask_q <= wr_merge(mask_q, wb_dat_i, wb_sel_i) & 32'h0f0f;
        `SSC_OFS_SMPCFG: smpcfg_q <= wr_merge(smpcfg_q, wb_dat_i, wb_sel_i) & 32'h7373;
        `SSC_OFS_MUX: mux_q <= 12'(wr_merge({20'h0, mux_q}, wb_dat_i, wb_sel_i) & 32'h0fff);
        default:
        begin
        end
      endcase
    end
  end

  always_comb
  begin
    rd_d = 32'h0;
    case (wb_adr_i)
      `SSC_OFS_CTRL: rd_d = ctrl_q;
      `SSC_OFS_INIT: rd_d = {16'h0, init_q};
      `SSC_OFS_HIGH: rd_d = {16'h0, high_q};
      `SSC_OFS_LOW: rd_d = {16'h0, low_q};
      `SSC_OFS_MASK: rd_d = mask_q;
      `SSC_OFS_SMPCFG: rd_d = smpcfg_q;
      `SSC_OFS_STAT: rd_d = {25'h0, smp_q, 2'h0, act_q, evt_q};
      `SSC_OFS_TGT: rd_d = {16'h0, tgt_q};
      `SSC_OFS_CNT: rd_d = cnt_q;
      `SSC_OFS_MUX: rd_d = {20'h0, mux_q};
      default: rd_d = 32'h0;
    endcase
  end

  // Unmapped addresses still ack, reading zero, so a master never hangs
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_d : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // Counter and compare
  // ---------------------------------------------------------------
  logic [15:0] view;
  logic [15:0] cmp_mask;
  logic [15:0] acc_mask;
  logic [15:0] cur_tgt;
  logic match;
  logic match_prev_q;
  logic event_p;
  logic out_q;
  logic [15:0] reload;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt_q <= 32'h0;
    else if (cnt_wr)
      cnt_q <= wb_dat_i;
    else if (tick && counter_enable)
      cnt_q <= cnt_q + 32'h1;
  end

  // Counter counts 32 kHz cycles; the 16-bit view is always its low 16 bits, whatever the prescale field holds
  assign view = cnt_q[15:0];

  assign acc_mask = msken ? low_ones(per_w) : 16'hffff;
  assign cmp_mask = acc_mask & ~(msken ? low_ones(ot_w) : 16'h0000);
  assign cur_tgt = arlen ? tgt_q : init_q;
  assign match = ((view ^ cur_tgt) & cmp_mask) == 16'h0000;
  // Old level low means this event rises, so the on-time is added next
  assign reload = out_q ? low_q : high_q;

  // Without reload a single match window drives one event on its first cycle
  assign event_p = chen && counter_enable && tick && match && (arlen || !match_prev_q);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      match_prev_q <= 1'b0;
      tgt_q <= `SSC_RST_INIT;
    end
    else
    begin
      if (tick)
        match_prev_q <= match;
      if (!chen || !counter_enable)
        tgt_q <= init_q;
      else if (event_p && arlen)
        tgt_q <= (tgt_q & ~acc_mask) | ((tgt_q + reload) & acc_mask);
    end
  end

  // ---------------------------------------------------------------
  // Strobe output and event flag
  // ---------------------------------------------------------------
  // Reload mode toggles level on each event; otherwise a one-cycle pulse
  logic [15:0] pulse_cnt_q;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      out_q <= 1'b0;
      pulse_cnt_q <= 16'h0;
    end
    else if (!chen || !counter_enable)
    begin
      out_q <= 1'b0;
      pulse_cnt_q <= 16'h0;
    end
    else if (event_p)
    begin
      out_q <= arlen ? ~out_q : 1'b1;
      pulse_cnt_q <= 16'(`SSC_STRB_CYCLES);
    end
    else if (tick && !arlen && pulse_cnt_q != 16'h0)
    begin
      pulse_cnt_q <= pulse_cnt_q - 16'h1;
      if (pulse_cnt_q == 16'h1)
      begin
        out_q <= 1'b0;
      end
    end
  end

  assign strobe_out = out_q ^ ctrl_q[`SSC_CTRL_INV];
  assign strobe_out_n = ~strobe_out;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      evt_q <= 1'b0;
    else if (event_p)
      evt_q <= 1'b1;
    else if (stat_clr && wb_dat_i[`SSC_STAT_EVT])
      evt_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Input sampling
  // ---------------------------------------------------------------
  logic out_prev_q;
  logic smp_point;
  logic have_prev_q;
  logic [2:0] live;
  logic [2:0] en;
  logic hit;
  logic [2:0] exp_v;

  always_comb
  begin
    live = {pin_s2_q[mux_q[10:8]], pin_s2_q[mux_q[6:4]], pin_s2_q[mux_q[2:0]]};
  end

  assign smp_point = (smpcfg_q[`SSC_SMP_RE] && out_q && !out_prev_q) ||
                     (smpcfg_q[`SSC_SMP_FE] && !out_q && out_prev_q);
  assign en = smpcfg_q[`SSC_SMP_EN_LSB +: 3];
  assign exp_v = smpcfg_q[`SSC_SMP_EXP_LSB +: 3];

  always_comb
  begin
    hit = 1'b0;
    case (ssc_pkg::ssc_pattern_t'(smpcfg_q[`SSC_SMP_PTRN_LSB +: 2]))
      ssc_pkg::SSC_PT_CHANGED: hit = have_prev_q && ((live ^ smp_q) & en) != 3'h0;
      ssc_pkg::SSC_PT_SAME: hit = have_prev_q && ((live ^ smp_q) & en) == 3'h0;
      ssc_pkg::SSC_PT_EQ_EXP: hit = ((live ^ exp_v) & en) == 3'h0;
      ssc_pkg::SSC_PT_NE_EXP: hit = ((live ^ exp_v) & en) != 3'h0;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      out_prev_q <= 1'b0;
      have_prev_q <= 1'b0;
      smp_q <= 3'h0;
    end
    else
    begin
      out_prev_q <= out_q;
      if (en == 3'h0 || !chen || !counter_enable)
      begin
        have_prev_q <= 1'b0;
      end
      else if (smp_point)
      begin
        have_prev_q <= 1'b1;
        smp_q <= live;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      act_q <= 1'b0;
    else if (smp_point && en != 3'h0 && chen && counter_enable && hit)
      act_q <= 1'b1;
    else if (stat_clr && wb_dat_i[`SSC_STAT_ACT])
      act_q <= 1'b0;
  end

  assign irq = (evt_q & ctrl_q[`SSC_CTRL_IRQEN]) | (act_q & ctrl_q[`SSC_CTRL_SMPIRQEN]);
  assign wakeup = irq;
endmodule

// ==== tb/ssc_strobe_channel_asserts.sv ====
// Port checker of the strobe channel
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick_32k,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic strobe_out,
  input wire logic strobe_out_n,
  input wire logic irq,
  input wire logic wakeup
);
  // ------
  // Age since last tick rise or ack
  // ------
  logic [3:0] age_q;
  logic tick_q;
  always_ff @(posedge mclk)
  begin
    tick_q <= tick_32k;
    if (!rst_n || (tick_32k && !tick_q) || wb_ack_o)
      age_q <= 4'h0;
    else if (age_q != 4'hf)
      age_q <= age_q + 4'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("ack missing");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
  property p_stat_rsvd;
    wb_ack_o && $past(wb_adr_i) == `SSC_OFS_STAT && !$past(wb_we_i)
      |-> wb_dat_o[31:7] == 25'h0 && wb_dat_o[3:2] == 2'h0;
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status spare bits set");
  property p_pair; strobe_out_n == !strobe_out; endproperty
  a_pair: assert property (p_pair) else $error("pair not inverse");
  property p_wake; wakeup == irq; endproperty
  a_wake: assert property (p_wake) else $error("wakeup differs from irq");
  // Outputs move only shortly after a tick or a register access
  property p_strb_cause; $changed(strobe_out) |-> age_q < 4'ha || wb_ack_o; endproperty
  a_strb_cause: assert property (p_strb_cause) else $error("strobe moved alone");
  property p_irq_cause; $rose(irq) |-> age_q < 4'ha || wb_ack_o; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose alone");
endmodule
bind ssc_strobe_channel ssc_chk u_ssc_chk (.mclk, .rst_n, .tick_32k, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .strobe_out, .strobe_out_n, .irq, .wakeup);

// ==== tb/ssc_sensor.sv ====
// Sensor model presenting a new reading at each strobe prompt
`timescale 1ns/1ps
module ssc_sensor (
  input wire logic mclk,
  input wire logic arm,
  input wire logic strobe_out,
  output logic [7:0] pins
);
  // ------
  // Readings
  // ------
  int seq[4] = '{5, 7, 3, 7};
  int n = 0;
  logic prev = 1'b0;
  // Unused pins toggle so no stale level passes for data
  always @(posedge mclk)
  begin
    prev <= strobe_out;
    pins[7:3] <= ~pins[7:3];
    if (!arm)
      n <= 0;
    else if (strobe_out && !prev)
    begin
      pins[2:0] <= seq[n % 4][2:0];
      n <= n + 1;
    end
  end
  initial pins = 8'h00;
endmodule

// ==== tb/ssc_strobe_channel_bench.sv ====
// Self-checking bench of the strobe channel
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_strobe_channel_bench;
  logic mclk = 1'b0, rst_n = 1'b0, tick_32k = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, arm = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] pins;
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic ack, s_out, irq, wakeup;
  int error_cnt = 0, checked = 0, cyc_n = 0, tick_n = 0;
  int h, l, t0, tg, e, pv, act;
  int seq[4] = '{5, 7, 3, 7};
  ssc_strobe_channel u_ssc_strobe_channel (.mclk, .rst_n, .tick_32k, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .sample_pins(pins), .strobe_out(s_out),
    .strobe_out_n(), .irq, .wakeup);
  ssc_sensor u_ssc_sensor (.mclk, .arm, .strobe_out(s_out), .pins);
  // ------
  // Clock, fast tick, watchdog
  // ------
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  // Tick every 16 cycles instead of a real 32 kHz rate keeps the run short
  always @(posedge mclk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n % 8 == 7)
      tick_32k <= ~tick_32k;
    if (cyc_n % 16 == 7)
      tick_n <= tick_n + 1;
    if (cyc_n == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, x, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge mclk);
    while (ack !== 1'b1)
      @(posedge mclk);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    chk(nm, x, rd);
  endtask
  task automatic lvl(input logic v);
    while (s_out !== v)
      @(posedge mclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  initial
  begin
    void'($urandom(40));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rchk("init", `SSC_OFS_INIT, `SSC_RST_INIT);
    rchk("high", `SSC_OFS_HIGH, `SSC_RST_DUR);
    rchk("low", `SSC_OFS_LOW, `SSC_RST_DUR);
    rchk("hole", 8'h3c, 32'h0);
    h = 2 + $urandom % 6;
    l = 2 + $urandom % 6;
    wb(1, `SSC_OFS_CNT, 0);
    wb(1, `SSC_OFS_INIT, 5);
    wb(1, `SSC_OFS_HIGH, h);
    wb(1, `SSC_OFS_LOW, l);
    wb(1, `SSC_OFS_CTRL, 32'h1a);
    rchk("first target", `SSC_OFS_TGT, 5);
    wb(1, `SSC_OFS_CTRL, 32'h1b);
    tg = 5;
    for (int i = 0; i < 6; i++)
    begin
      lvl(i % 2 == 0);
      if (i > 0)
        chk("interval", (i % 2) ? h : l, tick_n - t0);
      t0 = tick_n;
      tg = (tg + ((i % 2) ? l : h)) % 65536;
      rchk("target", `SSC_OFS_TGT, tg);
    end
    wb(0, `SSC_OFS_STAT, 0);
    chk("event", 1, rd[0]);
    chk("irq", 1, irq);
    wb(1, `SSC_OFS_STAT, 1);
    wb(0, `SSC_OFS_STAT, 0);
    chk("cleared", 0, rd[0]);
    chk("wakeup", 0, wakeup);
    wb(1, `SSC_OFS_CTRL, 32'h0b);
    lvl(1);
    wb(0, `SSC_OFS_STAT, 0);
    chk("sticky", 1, rd[0]);
    chk("masked", 0, irq);
    lvl(0);
    wb(1, `SSC_OFS_CTRL, 0);
    // Mask only: low two count bits compared
    wb(1, `SSC_OFS_CNT, 0);
    wb(1, `SSC_OFS_INIT, 3);
    wb(1, `SSC_OFS_MASK, 2);
    wb(1, `SSC_OFS_CTRL, 32'h06);
    wb(1, `SSC_OFS_CTRL, 32'h07);
    for (int i = 0; i < 3; i++)
    begin
      lvl(1);
      if (i > 0)
        chk("period", 4, tick_n - t0);
      t0 = tick_n;
      lvl(0);
      chk("on time", 1, tick_n - t0);
    end
    // Sampling on falling edge, every pattern code, two of three inputs
    wb(1, `SSC_OFS_MUX, 32'h210);
    for (int p = 0; p < 4; p++)
    begin
      e = $urandom % 8;
      wb(1, `SSC_OFS_CTRL, 0);
      wb(1, `SSC_OFS_SMPCFG, 0);
      wb(1, `SSC_OFS_STAT, 3);
      arm <= 1'b0;
      wb(1, `SSC_OFS_CNT, 0);
      arm <= 1'b1;
      wb(1, `SSC_OFS_SMPCFG, (e << 12) | (p << 8) | 32'h31);
      wb(1, `SSC_OFS_CTRL, 32'h26);
      wb(1, `SSC_OFS_CTRL, 32'h27);
      for (int k = 0; k < 4; k++)
      begin
        lvl(1);
        lvl(0);
        wb(0, `SSC_OFS_STAT, 0);
        pv = (seq[k] ^ ((k > 0) ? seq[k - 1] : 0)) & 3;
        case (p)
          0: act = (k > 0) && (pv != 0);
          1: act = (k > 0) && (pv == 0);
          2: act = ((seq[k] ^ e) & 3) == 0;
          default: act = ((seq[k] ^ e) & 3) != 0;
        endcase
        chk("sample", seq[k], rd[6:4]);
        chk("activity", act, rd[1]);
        chk("irq", act, irq);
        wb(1, `SSC_OFS_STAT, 3);
      end
    end
    report_and_stop();
  end
endmodule
